//--- txalign_pkg.sv
// shared constants and types for the tx clock-crossing control pair
package txalign_pkg;
    localparam int LANES = 2;
    localparam logic [19:0] TX_PMA_CONFIG_DEFAULT = 20'h80082;
    localparam logic [2:0] INVERT_BUFFERED = 3'h3;
    localparam logic [2:0] INVERT_BYPASS = 3'h7;
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;
    localparam int PRE_PHASE_CYCLES = 32;
    localparam int HOLD_DIV1_CYCLES = 8192;
    localparam int HOLD_DIV2_CYCLES = 16384;
    localparam int HOLD_DIV4_CYCLES = 32767;
    localparam int RESET_PULSE_CYCLES = 4;
    localparam int CNT_W = 16;
    localparam int STATUS_OVERRUN_BIT = 1;
    localparam int STATUS_HALF_BIT = 0;
    localparam int BUF_DEPTH = 16;
    localparam int PTR_W = 5;
    localparam logic [PTR_W-1:0] BUF_HALF = 5'h08;

    typedef enum logic {
        internal_output_clock_choice,
        user_clock_choice
    } clock_choice_t;

    // hold length of set_phase per divider setting
    function automatic logic [CNT_W-1:0] hold_cycles(input logic [1:0] div);
        case (div)
            DIV_BY_1: hold_cycles = CNT_W'(HOLD_DIV1_CYCLES);
            DIV_BY_2: hold_cycles = CNT_W'(HOLD_DIV2_CYCLES);
            default: hold_cycles = CNT_W'(HOLD_DIV4_CYCLES);
        endcase
    endfunction
endpackage

//--- txalign_if.sv
// link between the transceiver tile model and the fabric control logic
`timescale 1ns/10ps
interface txalign_if;
    import txalign_pkg::*;
    logic oversample_enable;
    logic [1:0] tx_clock_divider [LANES];
    logic [19:0] tx_pma_config_word [LANES];
    logic tx_buffer_use [LANES];
    clock_choice_t post_buffer_clock_select [LANES];
    logic [2:0] clock_path_inverters [LANES];
    logic tile_reset;
    logic tx_reset_a [LANES];
    logic align_enable [LANES];
    logic set_phase [LANES];
    logic pll_power_down_b;
    logic pll_lock_detect;
    logic [1:0] tx_buffer_flags [LANES];
    logic aligned [LANES];

    modport device (
        input oversample_enable, tx_clock_divider, tx_pma_config_word, tx_buffer_use,
        input post_buffer_clock_select, clock_path_inverters, tile_reset, tx_reset_a,
        input align_enable, set_phase, pll_power_down_b,
        output pll_lock_detect, tx_buffer_flags, aligned
    );
    modport ctrl (
        output oversample_enable, tx_clock_divider, tx_pma_config_word, tx_buffer_use,
        output post_buffer_clock_select, clock_path_inverters, tile_reset, tx_reset_a,
        output align_enable, set_phase, pll_power_down_b,
        input pll_lock_detect, tx_buffer_flags, aligned
    );
endinterface

//--- tx_buffer_phase_align_ctrl.sv
// fabric-side controller: configures tx crossing and runs per-lane phase alignment
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
module tx_buffer_phase_align_ctrl
    import txalign_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // user configuration
    input wire logic oversample_in,
    input wire logic buffer_use_in,
    input wire logic [1:0] divider_lane0_in,
    input wire logic [1:0] divider_lane1_in,
    input wire logic source_locked_in,
    input wire logic clock_changed_in,
    input wire logic tile_reset_req_in,
    input wire logic pll_power_down_in,
    // status
    output logic busy_out,
    output logic aligned_out,
    output logic buffer_error_out,
    // tile side
    txalign_if.ctrl tile
);
    // ****************************************
    // synchronisers for asynchronous pins
    // ****************************************
    logic lock_s1_r, lock_s2_r, src_s1_r, src_s2_r;
    logic [1:0] err_s1_r, err_s2_r;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
            src_s1_r <= 1'b0;
            src_s2_r <= 1'b0;
            err_s1_r <= 2'h0;
            err_s2_r <= 2'h0;
        end else begin
            lock_s1_r <= tile.pll_lock_detect;
            lock_s2_r <= lock_s1_r;
            src_s1_r <= source_locked_in;
            src_s2_r <= src_s1_r;
            err_s1_r <= {tile.tx_buffer_flags[1][STATUS_OVERRUN_BIT], tile.tx_buffer_flags[0][STATUS_OVERRUN_BIT]};
            err_s2_r <= err_s1_r;
        end
    end

    // ****************************************
    // static configuration
    // ****************************************
    // oversampling needs the buffer, so it forces buffered mode
    logic bypass;
    assign bypass = !buffer_use_in && !oversample_in;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tile.oversample_enable <= 1'b0;
            for (int i = 0; i < LANES; i++) begin
                tile.tx_clock_divider[i] <= DIV_BY_1;
                tile.tx_pma_config_word[i] <= TX_PMA_CONFIG_DEFAULT;
                tile.tx_buffer_use[i] <= 1'b1;
                tile.clock_path_inverters[i] <= INVERT_BUFFERED;
            end
        end else begin
            tile.oversample_enable <= oversample_in;
            tile.tx_clock_divider[0] <= divider_lane0_in;
            tile.tx_clock_divider[1] <= divider_lane1_in;
            for (int i = 0; i < LANES; i++) begin
                tile.tx_pma_config_word[i] <= TX_PMA_CONFIG_DEFAULT;
                tile.tx_buffer_use[i] <= !bypass;
                tile.clock_path_inverters[i] <= bypass ? INVERT_BYPASS : INVERT_BUFFERED;
            end
        end
    end

    // ****************************************
    // alignment sequence
    // ****************************************
    typedef enum logic [2:0] {
        st_idle, st_wait_lock, st_enable, st_pre, st_hold, st_restore, st_reset, st_done
    } seq_state_t;
    seq_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic restart;
    logic lock_ok;
    logic buf_err;
    logic mode_change;
    // a mode switch reruns the sequence, so the enable never rises without it
    assign mode_change = (bypass == tile.tx_buffer_use[0]);
    // realign on tile reset, power-up release, clock change or mode switch
    assign restart = tile_reset_req_in || pll_power_down_in || clock_changed_in || mode_change;
    assign lock_ok = lock_s2_r && src_s2_r;
    assign buf_err = |err_s2_r;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= st_idle;
            cnt_r <= '0;
        end else if (restart) begin
            state_r <= st_idle;
            cnt_r <= '0;
        end else begin
            case (state_r)
                st_idle: state_r <= st_wait_lock;
                st_wait_lock: if (lock_ok) state_r <= bypass ? st_enable : st_reset;
                st_enable: begin
                    state_r <= st_pre;
                    cnt_r <= CNT_W'(PRE_PHASE_CYCLES - 1);
                end
                st_pre: begin
                    if (cnt_r == '0) begin
                        state_r <= st_hold;
                        cnt_r <= hold_cycles(divider_lane0_in) - 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                st_hold: begin
                    if (cnt_r == '0) state_r <= st_restore;
                    else cnt_r <= cnt_r - 1'b1;
                end
                st_restore: begin
                    state_r <= st_reset;
                    cnt_r <= CNT_W'(RESET_PULSE_CYCLES - 1);
                end
                st_reset: begin
                    if (cnt_r == '0) state_r <= st_done;
                    else cnt_r <= cnt_r - 1'b1;
                end
                st_done: begin
                    // an error in the buffer re-runs the tx reset
                    if (buf_err && !bypass) begin
                        state_r <= st_reset;
                        cnt_r <= CNT_W'(RESET_PULSE_CYCLES - 1);
                    end
                end
                default: state_r <= st_idle;
            endcase
        end
    end

    // ****************************************
    // tile-wide controls
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tile.tile_reset <= 1'b1;
            tile.pll_power_down_b <= 1'b0;
        end else begin
            tile.tile_reset <= tile_reset_req_in;
            tile.pll_power_down_b <= !pll_power_down_in;
        end
    end

    // ****************************************
    // per-lane alignment controls
    // ****************************************
    // lane 1 uses lane 0 hold length; both lanes must share the divider when aligned together
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < LANES; i++) begin
                tile.align_enable[i] <= 1'b0;
                tile.set_phase[i] <= 1'b0;
                tile.tx_reset_a[i] <= 1'b1;
                tile.post_buffer_clock_select[i] <= internal_output_clock_choice;
            end
        end else begin
            for (int i = 0; i < LANES; i++) begin
                // one release edge for all lanes keeps them deskewed
                tile.tx_reset_a[i] <= (state_r == st_reset) || (state_r == st_idle) || (state_r == st_wait_lock);
                tile.post_buffer_clock_select[i] <= (state_r == st_enable || state_r == st_pre || state_r == st_hold)
                    ? user_clock_choice : internal_output_clock_choice;
                tile.align_enable[i] <= bypass && !restart
                    && (state_r inside {st_pre, st_hold, st_restore, st_reset, st_done});
                // high on every hold cycle; dropped with the enable so it never stands alone
                tile.set_phase[i] <= (state_r == st_hold) && !restart;
            end
        end
    end

    // ****************************************
    // status outputs
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b1;
            aligned_out <= 1'b0;
            buffer_error_out <= 1'b0;
        end else begin
            busy_out <= (state_r != st_done);
            aligned_out <= (state_r == st_done);
            buffer_error_out <= buf_err;
        end
    end
endmodule

//--- tx_tile_model.sv
// device side: tile transmit crossing, buffer flags and phase alignment behaviour
`timescale 1ns/10ps
module tx_tile_model
    import txalign_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // user data side
    input wire logic [LANES-1:0] write_in,
    input wire logic [LANES-1:0] read_in,
    input wire logic pll_locked_in,
    // status
    output logic [LANES-1:0] oversampling_out,
    output logic [LANES-1:0] aligned_out,
    // control side
    txalign_if.device tile
);
    // ****************************************
    // lock detect
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) tile.pll_lock_detect <= 1'b0;
        else tile.pll_lock_detect <= pll_locked_in && tile.pll_power_down_b && !tile.tile_reset;
    end

    // ****************************************
    // per-lane buffer occupancy and alignment
    // ****************************************
    for (genvar g = 0; g < LANES; g++) begin : lane
        logic [PTR_W-1:0] fill_r;
        logic [CNT_W-1:0] phase_cnt_r;
        logic lane_rst;
        assign lane_rst = tile.tile_reset || tile.tx_reset_a[g];
        always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                fill_r <= '0;
                tile.tx_buffer_flags[g] <= 2'h0;
            end else if (lane_rst) begin
                fill_r <= '0;
                tile.tx_buffer_flags[g] <= 2'h0;
            end else if (tile.tx_buffer_use[g]) begin
                // a refused push or pop leaves the level alone; the error stays until tx reset or tile reset
                if (write_in[g] && !read_in[g]) begin
                    if (fill_r == PTR_W'(BUF_DEPTH)) tile.tx_buffer_flags[g][STATUS_OVERRUN_BIT] <= 1'b1;
                    else fill_r <= fill_r + 1'b1;
                end else if (read_in[g] && !write_in[g]) begin
                    if (fill_r == '0) tile.tx_buffer_flags[g][STATUS_OVERRUN_BIT] <= 1'b1;
                    else fill_r <= fill_r - 1'b1;
                end
                tile.tx_buffer_flags[g][STATUS_HALF_BIT] <= (fill_r >= BUF_HALF);
            end
        end
        always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                phase_cnt_r <= '0;
                aligned_out[g] <= 1'b0;
            end else if (!tile.align_enable[g] || tile.tile_reset) begin
                phase_cnt_r <= '0;
                aligned_out[g] <= 1'b0;
            end else if (tile.set_phase[g]) begin
                if (phase_cnt_r != '1) phase_cnt_r <= phase_cnt_r + 1'b1;
            end else if (phase_cnt_r >= hold_cycles(tile.tx_clock_divider[g])) begin
                aligned_out[g] <= 1'b1;
            end
        end
        always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) oversampling_out[g] <= 1'b0;
            else oversampling_out[g] <= tile.oversample_enable;
        end
    end
    assign tile.aligned = '{aligned_out[0], aligned_out[1]};
endmodule

//--- txalign_assertions.sv
// concurrent checks on the link between controller and tile model
`timescale 1ns/10ps
module txalign_assertions
    import txalign_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // link signals
    input wire logic [19:0] tx_pma_config_word [LANES],
    input wire logic tx_buffer_use [LANES],
    input clock_choice_t post_buffer_clock_select [LANES],
    input wire logic [2:0] clock_path_inverters [LANES],
    input wire logic tile_reset,
    input wire logic tx_reset_a [LANES],
    input wire logic align_enable [LANES],
    input wire logic set_phase [LANES],
    input wire logic [1:0] tx_buffer_flags [LANES]
);
    // ****************
    // link properties
    // ****************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_cfg_word_default: assert property (tx_pma_config_word[0] == TX_PMA_CONFIG_DEFAULT)
        else $error("config word not default");
    a_invert_by_mode: assert property (tx_buffer_use[0] [*2] |-> clock_path_inverters[0] == INVERT_BUFFERED)
        else $error("inverters wrong when buffered");
    a_select_buffered: assert property (tx_buffer_use[0] [*4] |-> post_buffer_clock_select[0] == internal_output_clock_choice)
        else $error("select not internal when buffered");
    a_enable_after_select: assert property ($rose(align_enable[0]) |-> post_buffer_clock_select[0] == user_clock_choice)
        else $error("enable raised before select");
    a_pre_phase_count: assert property ($rose(set_phase[0]) |-> $past(align_enable[0], 32))
        else $error("set phase too early");
    a_phase_in_align: assert property (set_phase[0] |-> align_enable[0] && !tx_buffer_use[0])
        else $error("set phase outside alignment");
    a_lanes_paired: assert property (align_enable[0] == align_enable[1] && set_phase[0] == set_phase[1])
        else $error("lanes out of step");
    a_reset_after_hold: assert property ($fell(set_phase[0]) && align_enable[0] |-> ##[1:8] tx_reset_a[0])
        else $error("no tx reset after hold");
    a_flag_sticky: assert property ($past(tx_buffer_flags[0][1]) && !$past(tx_reset_a[0]) && !$past(tile_reset)
        |-> tx_buffer_flags[0][1])
        else $error("error flag not sticky");
    // flags are cleared by a held tile reset
    a_tile_reset_flags: assert property (tile_reset [*3] |-> tx_buffer_flags[0] == 2'h0)
        else $error("flags survive tile reset");
    c_hold_done: cover property ($fell(set_phase[0]));
    c_overrun: cover property ($rose(tx_buffer_flags[0][1]));
    c_tile_reset: cover property ($rose(tile_reset));
endmodule

//--- tx_buffer_phase_align_ctrl_tb.sv
// self-checking bench for the controller and tile model pair
`timescale 1ns/10ps
module tx_buffer_phase_align_ctrl_tb;
    import txalign_pkg::*;
    logic sys_clk_in, rst_n_in, oversample_in, buffer_use_in, source_locked_in, pll_locked_in;
    logic clock_changed_in, tile_reset_req_in, pll_power_down_in, busy_out, aligned_out, buffer_error_out;
    logic [1:0] divider_in, write_in, read_in, oversampling_out, dev_aligned;
    logic seen_err, seen_half;
    int miscompares = 0;
    int checked = 0;
    int n;
    txalign_if tile_if();
    // lane 1 shares the divider input: its hold length follows lane 0 anyway
    tx_buffer_phase_align_ctrl tx_buffer_phase_align_ctrl_i(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .oversample_in(oversample_in), .buffer_use_in(buffer_use_in), .divider_lane0_in(divider_in),
        .divider_lane1_in(divider_in), .source_locked_in(source_locked_in), .clock_changed_in(clock_changed_in),
        .tile_reset_req_in(tile_reset_req_in), .pll_power_down_in(pll_power_down_in), .busy_out(busy_out),
        .aligned_out(aligned_out), .buffer_error_out(buffer_error_out), .tile(tile_if.ctrl));
    tx_tile_model tx_tile_model_i(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .write_in(write_in),
        .read_in(read_in), .pll_locked_in(pll_locked_in), .oversampling_out(oversampling_out),
        .aligned_out(dev_aligned), .tile(tile_if.device));
    txalign_assertions txalign_assertions_i(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .tx_pma_config_word(tile_if.tx_pma_config_word), .tx_buffer_use(tile_if.tx_buffer_use),
        .post_buffer_clock_select(tile_if.post_buffer_clock_select), .tile_reset(tile_if.tile_reset),
        .clock_path_inverters(tile_if.clock_path_inverters), .tx_reset_a(tile_if.tx_reset_a),
        .align_enable(tile_if.align_enable), .set_phase(tile_if.set_phase), .tx_buffer_flags(tile_if.tx_buffer_flags));
    // ****************
    // helpers
    // ****************
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic tick();
        @(posedge sys_clk_in);
        #1;
    endtask
    task automatic summarize();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    function automatic logic probe(input int sel);
        case (sel)
            0: return tile_if.align_enable[0];
            1: return tile_if.set_phase[0];
            2: return aligned_out;
            3: return busy_out;
            5: return buffer_error_out;
            default: return tile_if.tx_buffer_flags[0][STATUS_OVERRUN_BIT];
        endcase
    endfunction
    // n counts the cycles spent waiting
    task automatic wait_on(input int sel, input logic val, input int bound);
        n = 0;
        while (probe(sel) !== val && n < bound) begin
            tick();
            n++;
        end
        if (probe(sel) !== val) begin
            miscompares++;
            $display("FAIL wait %0d expected %0b seen %0b", sel, val, probe(sel));
            summarize();
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_align(input logic [1:0] div, input logic [31:0] hold);
        buffer_use_in <= 1'b0;
        divider_in <= div;
        wait_on(0, 1'b1, 2000);
        chk("select at enable", user_clock_choice, tile_if.post_buffer_clock_select[1]);
        chk("inverters bypass", INVERT_BYPASS, tile_if.clock_path_inverters[1]);
        wait_on(1, 1'b1, 64);
        chk("pre phase cycles", PRE_PHASE_CYCLES, n);
        wait_on(1, 1'b0, 40000);
        chk("hold cycles", hold, n);
        wait_on(2, 1'b1, 100);
        chk("select restored", internal_output_clock_choice, tile_if.post_buffer_clock_select[0]);
        chk("tx reset released", 1'h0, tile_if.tx_reset_a[1]);
        chk("enable kept", 1'h1, tile_if.align_enable[1]);
        chk("tile aligned", 2'h3, dev_aligned);
    endtask
    task automatic t_restart(input int sel);
        {pll_power_down_in, tile_reset_req_in, clock_changed_in} <= 3'h1 << sel;
        wait_on(0, 1'b0, 20);
        tick();
        chk("ctrl aligned dropped", 1'h0, aligned_out);
        chk("tile aligned lost", 2'h0, dev_aligned);
        if (sel == 1)
            chk("tile reset", 1'h1, tile_if.tile_reset);
        {pll_power_down_in, tile_reset_req_in, clock_changed_in} <= 3'h0;
        tick();
    endtask
    task automatic t_oversample();
        oversample_in <= 1'b1;
        repeat (6) tick();
        chk("oversampling on", 2'h3, oversampling_out);
        chk("forced buffered", INVERT_BUFFERED, tile_if.clock_path_inverters[0]);
        chk("select buffered", internal_output_clock_choice, tile_if.post_buffer_clock_select[1]);
        oversample_in <= 1'b0;
        repeat (6) tick();
        chk("oversampling off", 2'h0, oversampling_out);
    endtask
    task automatic t_buffer(input int mode);
        buffer_use_in <= 1'b1;
        wait_on(3, 1'b0, 2000);
        seen_err = 1'b0;
        seen_half = 1'b0;
        repeat (mode ? 4 : BUF_DEPTH + 6) begin
            write_in <= mode ? 2'h0 : 2'h3;
            read_in <= mode ? 2'h3 : 2'h0;
            tick();
            seen_half |= tile_if.tx_buffer_flags[0][STATUS_HALF_BIT];
            seen_err |= tile_if.tx_buffer_flags[0][STATUS_OVERRUN_BIT];
        end
        write_in <= 2'h0;
        read_in <= 2'h0;
        chk("half full seen", mode ? 1'h0 : 1'h1, seen_half);
        chk("overrun seen", 1'h1, seen_err);
        wait_on(5, 1'b1, 10);
        wait_on(4, 1'b0, 50);
        wait_on(5, 1'b0, 10);
    endtask
    initial begin
        {rst_n_in, oversample_in, buffer_use_in, source_locked_in, pll_locked_in} = 5'h0;
        {clock_changed_in, tile_reset_req_in, pll_power_down_in, write_in, read_in} = 7'h0;
        divider_in = DIV_BY_1;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        pll_locked_in <= 1'b1;
        repeat (20) tick();
        chk("enable before source lock", 1'h0, tile_if.align_enable[0]);
        source_locked_in <= 1'b1;
        t_align(DIV_BY_1, HOLD_DIV1_CYCLES);
        t_restart(0);
        t_align(DIV_BY_2, HOLD_DIV2_CYCLES);
        t_restart(2);
        t_align(DIV_BY_4, HOLD_DIV4_CYCLES);
        t_restart(1);
        t_oversample();
        t_buffer(0);
        t_buffer(1);
        summarize();
    end
endmodule
